// ### slt_top.sv
/*
  Front-panel status indicator controller of the interface control board.
  Assumes status inputs come from logic on clk; LEDs are active high,
  amber is red and green together.
*/
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module slt_top
  import slt_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SLT_SEC_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire slt_status_t       status,
  input  wire logic [SLT_AW-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_we,
  input  wire logic              reg_re,
  output logic [31:0]            reg_rdata,
  output slt_led_t               leds,
  output logic                   irq
);

  initial begin
    if (SEC_CYCLES < 2) begin
      $error("SEC_CYCLES must be at least 2");
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [0:0]         ctrl;
    logic [SLT_NEV-1:0] irq_sts;
    logic [SLT_NEV-1:0] irq_msk;
    logic [31:0]        rdata;
    slt_led_t           leds;
    logic               irq;
    logic               ext_prev;
    logic               alarm_prev;
    logic               locked_prev;
    logic               l2_prev;
    logic [2:0]         triple_cnt;
  } slt_state_t;

  slt_state_t st_q;
  slt_state_t st_d;

  // ----------------------------------------------------------------
  // Shared timebase
  // ----------------------------------------------------------------
  logic tick;
  logic phase;
  logic new_det;

  slt_timebase #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_timebase (
    .clk     (clk),
    .reset   (reset),
    .ce      (ce),
    .restart (new_det),
    .tick    (tick),
    .phase   (phase)
  );

  // ----------------------------------------------------------------
  // Board conditions
  // ----------------------------------------------------------------
  logic dark;
  logic bist;
  logic ext_present;

  assign dark        = (status.board == BS_OFF) || !st_q.ctrl[SLT_CTRL_PANEL];
  assign bist        = (status.board == BS_BIST);
  assign ext_present = (status.sync_mode == SM_GPS) || (status.sync_mode == SM_MASTER);
  assign new_det     = ext_present && !st_q.ext_prev;

  // ----------------------------------------------------------------
  // Colour selection of bicolour LEDs
  // ----------------------------------------------------------------
  slt_color_t [9:0] color;
  logic       [9:0] col_red;
  logic       [9:0] col_green;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      case (status.trunk[i])
        TRK_OK:    color[i] = COL_GREEN;
        TRK_FAULT: color[i] = COL_RED;
        TRK_TEST:  color[i] = COL_AMBER;
        default:   color[i] = COL_OFF;
      endcase
    end
    if (status.ext_sync_bad) begin
      color[8] = COL_RED;
    end else if (status.sync_mode == SM_MASTER) begin
      color[8] = COL_AMBER;
    end else if ((status.sync_mode == SM_GPS) || status.sync_holdover) begin
      color[8] = COL_GREEN;
    end else begin
      color[8] = COL_OFF;
    end
    if (status.config_unknown) begin
      color[9] = COL_RED;
    end else if (status.is_active) begin
      color[9] = COL_GREEN;
    end else begin
      color[9] = COL_OFF;
    end
  end

  for (genvar g = 0; g < 10; g++) begin : g_bicolor
    slt_bicolor u_bicolor (
      .color (color[g]),
      .dark  (dark),
      .bist  (bist),
      .red   (col_red[g]),
      .green (col_green[g])
    );
  end

  // ----------------------------------------------------------------
  // Read image of the LED register
  // ----------------------------------------------------------------
  logic [13:0] led_word;

  assign led_word = {st_q.leds.corp_red,
                     st_q.leds.corp_green,
                     st_q.leds.ext_red,
                     st_q.leds.ext_green,
                     st_q.leds.sync_src,
                     st_q.leds.holdover,
                     st_q.leds.act_red,
                     st_q.leds.act_green,
                     st_q.leds.backhaul,
                     st_q.triple_cnt != 3'h0,
                     phase};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [SLT_NEV-1:0] ev;
  logic [SLT_NEV-1:0] clr;
  logic [3:0]         src_code;
  logic               hold_on;
  logic               triple_on;

  always_comb begin
    st_d = st_q;

    // Edge detection of board events
    // Detectors start low, so a level present at reset release is an event, except a backhaul link already down
    st_d.ext_prev    = ext_present;
    st_d.alarm_prev  = (status.board == BS_ALARM);
    st_d.locked_prev = status.sync_locked;
    st_d.l2_prev     = status.l2_up;
    ev                = '0;
    ev[SLT_EV_EXTDET] = new_det;
    ev[SLT_EV_ALARM]  = (status.board == BS_ALARM) && !st_q.alarm_prev;
    ev[SLT_EV_LOCKED] = status.sync_locked && !st_q.locked_prev;
    ev[SLT_EV_L2LOST] = !status.l2_up && st_q.l2_prev;

    // Triple blink on new external detection
    if (new_det) begin
      st_d.triple_cnt = SLT_TRIPLE_HALF;
    end else if (tick && (st_q.triple_cnt != 3'h0)) begin
      st_d.triple_cnt = st_q.triple_cnt - 3'h1;
    end
    // Lit on even counts, so each second turns over on the same edge as the phase
    triple_on = (st_d.triple_cnt != 3'h0) && !st_d.triple_cnt[0];

    // Corporate LEDs
    case (status.board)
      BS_BIST: begin
        st_d.leds.corp_red   = 1'b1;
        st_d.leds.corp_green = 1'b1;
      end
      BS_NORMAL: begin
        st_d.leds.corp_red   = 1'b0;
        st_d.leds.corp_green = 1'b1;
      end
      BS_PARTIAL: begin
        st_d.leds.corp_red   = phase;
        st_d.leds.corp_green = 1'b1;
      end
      BS_ALARM: begin
        st_d.leds.corp_red   = 1'b1;
        st_d.leds.corp_green = 1'b0;
      end
      BS_WAIT_ACT: begin
        st_d.leds.corp_red   = 1'b0;
        st_d.leds.corp_green = phase;
      end
      BS_DOWNLOAD: begin
        st_d.leds.corp_red   = phase;
        st_d.leds.corp_green = phase;
      end
      default: begin
        st_d.leds.corp_red   = 1'b0;
        st_d.leds.corp_green = 1'b0;
      end
    endcase
    if (!st_q.ctrl[SLT_CTRL_PANEL]) begin
      st_d.leds.corp_red   = 1'b0;
      st_d.leds.corp_green = 1'b0;
    end

    // Bicolour specific LEDs
    st_d.leds.trunk_red   = col_red[7:0];
    st_d.leds.trunk_green = col_green[7:0];
    st_d.leds.ext_red     = col_red[8];
    st_d.leds.ext_green   = col_green[8];
    st_d.leds.act_red     = col_red[9];
    st_d.leds.act_green   = col_green[9];

    // Sync-source LEDs
    src_code = {1'b0, status.sync_trunk} + 4'h1;
    if (dark) begin
      st_d.leds.sync_src = 4'h0;
    end else if (bist) begin
      st_d.leds.sync_src = 4'hF;
    end else if (ext_present) begin
      if (st_d.triple_cnt != 3'h0) begin
        st_d.leds.sync_src = {4{triple_on}};
      end else begin
        st_d.leds.sync_src = 4'hF;
      end
    end else if ((status.sync_mode == SM_TRUNK) || status.sync_holdover) begin
      st_d.leds.sync_src = src_code;
    end else begin
      st_d.leds.sync_src = 4'h0;
    end

    // Holdover LED: lock from the backhaul only counts once fully achieved
    if (status.is_active) begin
      hold_on = !status.sync_locked || status.sync_holdover;
    end else begin
      hold_on = !status.sync_locked;
    end
    if (dark) begin
      st_d.leds.holdover = 1'b0;
    end else if (bist) begin
      st_d.leds.holdover = 1'b1;
    end else begin
      st_d.leds.holdover = hold_on;
    end

    // Backhaul link LED
    if (dark) begin
      st_d.leds.backhaul = 1'b0;
    end else if (bist) begin
      st_d.leds.backhaul = 1'b1;
    end else if (status.l2_download) begin
      st_d.leds.backhaul = phase;
    end else begin
      st_d.leds.backhaul = status.l2_up;
    end

    // Register writes
    // Writes to unmapped offsets are dropped
    clr = '0;
    if (reg_we) begin
      if (reg_addr == SLT_OFS_CTRL) begin
        st_d.ctrl = reg_wdata[0:0];
      end else if (reg_addr == SLT_OFS_IRQ_STS) begin
        clr = reg_wdata[SLT_NEV-1:0];
      end else if (reg_addr == SLT_OFS_IRQ_MSK) begin
        st_d.irq_msk = reg_wdata[SLT_NEV-1:0];
      end
    end

    // Sticky status, a new event wins over a clear
    st_d.irq_sts = (st_q.irq_sts & ~clr) | ev;
    st_d.irq     = |(st_d.irq_sts & st_d.irq_msk);

    // Register reads, data stand for one cycle only
    st_d.rdata = 32'h0000_0000;
    if (reg_re) begin
      if (reg_addr == SLT_OFS_CTRL) begin
        st_d.rdata = {31'h0000_0000, st_q.ctrl};
      end else if (reg_addr == SLT_OFS_IRQ_STS) begin
        st_d.rdata = {28'h000_0000, st_q.irq_sts};
      end else if (reg_addr == SLT_OFS_IRQ_MSK) begin
        st_d.rdata = {28'h000_0000, st_q.irq_msk};
      end else if (reg_addr == SLT_OFS_LED) begin
        st_d.rdata = {18'h0_0000, led_word};
      end else if (reg_addr == SLT_OFS_TRUNK) begin
        st_d.rdata = {16'h0000, st_q.leds.trunk_red, st_q.leds.trunk_green};
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '{ctrl:        SLT_CTRL_RST,
                irq_sts:     SLT_IRQ_RST,
                irq_msk:     SLT_IRQ_RST,
                rdata:       32'h0000_0000,
                leds:        '0,
                irq:         1'b0,
                ext_prev:    1'b0,
                alarm_prev:  1'b0,
                locked_prev: 1'b0,
                l2_prev:     1'b0,
                triple_cnt:  3'h0};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = st_q.rdata;
  assign leds      = st_q.leds;
  assign irq       = st_q.irq;
endmodule

// ### slt_pkg.sv
/*
  Shared constants and types of the status LED indicator controller.
  Assumes one 250 MHz board clock and internal status sources on that clock.
*/
package slt_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SLT_CLK_HZ      = 250_000_000;
  localparam int unsigned SLT_BLINK_SEC   = 1;
  localparam int unsigned SLT_SEC_CYCLES  = SLT_CLK_HZ * SLT_BLINK_SEC;
  localparam logic [2:0]  SLT_TRIPLE_HALF = 3'h6;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned SLT_AW          = 8;
  localparam logic [7:0]  SLT_OFS_CTRL    = 8'h00;
  localparam logic [7:0]  SLT_OFS_IRQ_STS = 8'h04;
  localparam logic [7:0]  SLT_OFS_IRQ_MSK = 8'h08;
  localparam logic [7:0]  SLT_OFS_LED     = 8'h0C;
  localparam logic [7:0]  SLT_OFS_TRUNK   = 8'h10;
  localparam int unsigned SLT_CTRL_PANEL  = 0;
  localparam logic [0:0]  SLT_CTRL_RST    = 1'h1;
  localparam int unsigned SLT_NEV         = 4;
  localparam int unsigned SLT_EV_EXTDET   = 0;
  localparam int unsigned SLT_EV_ALARM    = 1;
  localparam int unsigned SLT_EV_LOCKED   = 2;
  localparam int unsigned SLT_EV_L2LOST   = 3;
  localparam logic [3:0]  SLT_IRQ_RST     = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BS_OFF      = 3'b000,
    BS_BIST     = 3'b001,
    BS_NORMAL   = 3'b010,
    BS_PARTIAL  = 3'b011,
    BS_ALARM    = 3'b100,
    BS_WAIT_ACT = 3'b101,
    BS_DOWNLOAD = 3'b110
  } slt_board_t;

  typedef enum logic [1:0] {
    TRK_OK     = 2'b00,
    TRK_FAULT  = 2'b01,
    TRK_TEST   = 2'b10,
    TRK_UNUSED = 2'b11
  } slt_trunk_t;

  typedef enum logic [1:0] {
    SM_NONE   = 2'b00,
    SM_TRUNK  = 2'b01,
    SM_GPS    = 2'b10,
    SM_MASTER = 2'b11
  } slt_sync_t;

  typedef enum logic [1:0] {
    COL_OFF   = 2'b00,
    COL_GREEN = 2'b01,
    COL_RED   = 2'b10,
    COL_AMBER = 2'b11
  } slt_color_t;

  typedef struct packed {
    slt_board_t      board;
    logic            is_active;
    logic            config_unknown;
    slt_sync_t       sync_mode;
    logic [2:0]      sync_trunk;
    logic            sync_holdover;
    logic            sync_locked;
    logic            ext_sync_bad;
    logic            l2_up;
    logic            l2_download;
    slt_trunk_t [7:0] trunk;
  } slt_status_t;

  typedef struct packed {
    logic       corp_red;
    logic       corp_green;
    logic [7:0] trunk_red;
    logic [7:0] trunk_green;
    logic       ext_red;
    logic       ext_green;
    logic [3:0] sync_src;
    logic       holdover;
    logic       act_red;
    logic       act_green;
    logic       backhaul;
  } slt_led_t;

endpackage

// ### slt_timebase.sv
/*
  One-second timebase shared by all blinking LEDs.
  Assumes restart is a same-clock pulse; the phase is high in the first second.
*/
`timescale 1ns/1ps
module slt_timebase
  import slt_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SLT_SEC_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic restart,
  output logic      tick,
  output logic      phase
);
  localparam int unsigned CW = $clog2(SEC_CYCLES);

  initial begin
    if (SEC_CYCLES < 2) begin
      $error("SEC_CYCLES must be at least 2");
    end
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          phase;
  } slt_tb_state_t;

  slt_tb_state_t st_q;
  slt_tb_state_t st_d;
  logic          wrap;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    wrap = (st_q.cnt == CW'(SEC_CYCLES - 1));
    if (restart) begin
      st_d.cnt   = '0;
      st_d.phase = 1'b1;
    end else if (wrap) begin
      st_d.cnt   = '0;
      st_d.phase = ~st_q.phase;
    end else begin
      st_d.cnt = st_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '{cnt: '0, phase: 1'b1};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign tick  = wrap & ~restart;
  assign phase = st_q.phase;
endmodule

// ### slt_bicolor.sv
/*
  Colour encoder of one red/green LED.
  Assumes dark overrides the self-test amber, which overrides the colour.
*/
`timescale 1ns/1ps
module slt_bicolor
  import slt_pkg::*;
(
  input  wire slt_color_t color,
  input  wire logic       dark,
  input  wire logic       bist,
  output logic            red,
  output logic            green
);
  // ----------------------------------------------------------------
  // Encoding
  // ----------------------------------------------------------------
  always_comb begin
    if (dark) begin
      red   = 1'b0;
      green = 1'b0;
    end else if (bist) begin
      red   = 1'b1;
      green = 1'b1;
    end else begin
      red   = color[1];
      green = color[0];
    end
  end
endmodule

// ### slt_top_sva.sv
/*
  Checker of the LED outputs and read port of slt_top.
  Assumes one clock domain; bound to slt_top and sees its ports only.
*/
`timescale 1ns/1ps
module slt_top_sva
  import slt_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SLT_SEC_CYCLES
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire logic              ce,
  input wire slt_status_t       status,
  input wire logic [SLT_AW-1:0] reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_we,
  input wire logic              reg_re,
  input wire logic [31:0]       reg_rdata,
  input wire slt_led_t          leds,
  input wire logic              irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // Panel enable tracker
  // ------------------------------------------------------------
  logic pan_q;
  logic ok;
  logic lit;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pan_q <= 1'b1;
    end else if (ce && reg_we && reg_addr == SLT_OFS_CTRL) begin
      pan_q <= reg_wdata[0];
    end
  end
  assign ok  = ce && pan_q && !(reg_we && reg_addr == SLT_OFS_CTRL);
  assign lit = ok && status.board != BS_OFF && status.board != BS_BIST;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_off; ok && status.board == BS_OFF |=> leds == '0; endproperty
  a_off: assert property (p_off) else $error("leds lit while off");
  property p_norm; ok && status.board == BS_NORMAL |=> !leds.corp_red && leds.corp_green;
  endproperty
  a_norm: assert property (p_norm) else $error("corporate pair wrong");
  property p_alarm; ok && status.board == BS_ALARM |=> !leds.corp_green; endproperty
  a_alarm: assert property (p_alarm) else $error("green on in alarm");
  property p_bist; ok && status.board == BS_BIST |=> leds == '1; endproperty
  a_bist: assert property (p_bist) else $error("self test not amber");
  property p_trk; lit && status.trunk[1] == TRK_FAULT
    |=> leds.trunk_red[1] && !leds.trunk_green[1]; endproperty
  a_trk: assert property (p_trk) else $error("trunk fault not red");
  property p_src; lit && status.sync_mode == SM_TRUNK
    |=> leds.sync_src == {1'b0, $past(status.sync_trunk)} + 4'h1; endproperty
  a_src: assert property (p_src) else $error("sync source code wrong");
  property p_hold; lit |=> leds.holdover == (!$past(status.sync_locked)
    || ($past(status.is_active) && $past(status.sync_holdover))); endproperty
  a_hold: assert property (p_hold) else $error("holdover led wrong");
  property p_act; lit |=> leds.act_red == $past(status.config_unknown) && leds.act_green ==
    ($past(status.is_active) && !$past(status.config_unknown)); endproperty
  a_act: assert property (p_act) else $error("activity led wrong");
  property p_bh; lit && !status.l2_download |=> leds.backhaul == $past(status.l2_up); endproperty
  a_bh: assert property (p_bh) else $error("backhaul led wrong");
  property p_rd; ce && !reg_re |=> reg_rdata == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data not cleared");
  property p_frz; !ce |=> $stable(leds) && $stable(irq); endproperty
  a_frz: assert property (p_frz) else $error("outputs moved while frozen");
endmodule

bind slt_top slt_top_sva #(.SEC_CYCLES(SEC_CYCLES)) u_sva (.clk(clk), .reset(reset), .ce(ce),
  .status(status), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .leds(leds), .irq(irq));

// ### slt_panel_model.sv
/*
  Front panel as a technician sees it: colour of each trunk, external-sync and activity two-colour LED.
  Assumes active-high LEDs, amber being red and green together.
*/
`timescale 1ns/1ps
module slt_panel_model
  import slt_pkg::*;
(
  input  wire slt_led_t    leds,
  output slt_color_t [7:0] trunk_col,
  output slt_color_t       ext_col,
  output slt_color_t       act_col
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      trunk_col[i] = slt_color_t'({leds.trunk_red[i], leds.trunk_green[i]});
    end
    ext_col = slt_color_t'({leds.ext_red, leds.ext_green});
    act_col = slt_color_t'({leds.act_red, leds.act_green});
  end
endmodule

// ### slt_top_bench.sv
/*
  Self-checking bench of slt_top with a short one-second count.
  Assumes the package constants and the panel model.
*/
`timescale 1ns/1ps
module slt_top_bench;
  import slt_pkg::*;
  localparam int unsigned SEC = 10;
  logic              clk;
  logic              reset;
  logic              ce;
  slt_status_t       st;
  logic [SLT_AW-1:0] reg_addr;
  logic [31:0]       reg_wdata;
  logic              reg_we;
  logic              reg_re;
  logic [31:0]       reg_rdata;
  slt_led_t          leds;
  logic              irq;
  slt_color_t [7:0]  tcol;
  slt_color_t        ecol;
  slt_color_t        acol;
  int                err_total;
  int                n_compared;

  slt_top #(.SEC_CYCLES(SEC)) i_dut (.clk(clk), .reset(reset), .ce(ce), .status(st),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .leds(leds), .irq(irq));
  slt_panel_model i_pan (.leds(leds), .trunk_col(tcol), .ext_col(ecol), .act_col(acol));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 cmp("rdata", e, reg_rdata);
  endtask
  task automatic put(input slt_status_t s);
    @(posedge clk);
    st <= s;
    repeat (2) @(posedge clk);
    #1;
  endtask
  function automatic slt_status_t nom();
    slt_status_t s;
    s = '0;
    s.board = BS_NORMAL;
    s.is_active = 1'b1;
    s.sync_mode = SM_TRUNK;
    s.sync_locked = 1'b1;
    s.l2_up = 1'b1;
    return s;
  endfunction
  task automatic corp(input slt_board_t b, input logic [1:0] e);
    slt_status_t s;
    s = nom();
    s.board = b;
    put(s);
    cmp("corp", 32'(e), 32'({leds.corp_red, leds.corp_green}));
  endtask
  task automatic blink(input slt_status_t s, input slt_led_t m);
    slt_led_t a;
    put(s);
    a = leds;
    repeat (SEC) @(posedge clk);
    #1 cmp("toggling", 32'(m), 32'(a ^ leds));
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_corp;
    slt_status_t s;
    slt_led_t m;
    s = nom();
    corp(BS_BIST, 2'b11);
    corp(BS_NORMAL, 2'b01);
    corp(BS_ALARM, 2'b10);
    corp(BS_OFF, 2'b00);
    m = '0;
    m.corp_red = 1'b1;
    s.board = BS_PARTIAL;
    blink(s, m);
    m.corp_green = 1'b1;
    s.board = BS_DOWNLOAD;
    blink(s, m);
    m.corp_red = 1'b0;
    s.board = BS_WAIT_ACT;
    blink(s, m);
  endtask
  task automatic t_trunk;
    slt_status_t s;
    slt_color_t tc[4];
    tc = '{COL_GREEN, COL_RED, COL_AMBER, COL_OFF};
    s = nom();
    for (int i = 0; i < 8; i++) s.trunk[i] = slt_trunk_t'(i % 4);
    put(s);
    for (int i = 0; i < 8; i++) cmp("trunk", 32'(tc[i % 4]), 32'(tcol[i]));
    rd(SLT_OFS_TRUNK, 32'h6655);
    s.board = BS_BIST;
    put(s);
    cmp("bist", 32'h0FFFFFFF, 32'(leds));
  endtask
  task automatic t_sync;
    slt_status_t s;
    slt_sync_t md[4];
    slt_color_t ec[4];
    md = '{SM_NONE, SM_GPS, SM_MASTER, SM_GPS};
    ec = '{COL_OFF, COL_GREEN, COL_AMBER, COL_RED};
    s = nom();
    for (int n = 0; n < 8; n++) begin
      s.sync_trunk = 3'(n);
      put(s);
      cmp("src", 32'(n + 1), 32'(leds.sync_src));
    end
    for (int k = 0; k < 4; k++) begin
      s.sync_mode = md[k];
      s.ext_sync_bad = (k == 3);
      put(s);
      cmp("ext", 32'(ec[k]), 32'(ecol));
    end
    s = nom();
    s.sync_mode = SM_NONE;
    s.sync_holdover = 1'b1;
    s.sync_locked = 1'b0;
    s.sync_trunk = 3'h5;
    put(s);
    cmp("hold src", 32'h6, 32'(leds.sync_src));
    cmp("hold led", 32'h1, 32'(leds.holdover));
    cmp("hold ext", 32'(COL_GREEN), 32'(ecol));
  endtask
  task automatic t_triple;
    slt_status_t s;
    s = nom();
    s.sync_mode = SM_NONE;
    put(s);
    s.sync_mode = SM_MASTER;
    @(posedge clk);
    st <= s;
    repeat (5) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      #1 cmp("triple", (k < 6 && k % 2 == 1) ? 32'h0 : 32'hF, 32'(leds.sync_src));
      repeat (SEC) @(posedge clk);
    end
    #1 cmp("ext steady", 32'hF, 32'(leds.sync_src));
  endtask
  task automatic t_misc;
    slt_status_t s;
    slt_led_t m;
    s = nom();
    for (int k = 0; k < 8; k++) begin
      {s.is_active, s.sync_locked, s.sync_holdover} = 3'(k);
      put(s);
      cmp("hold", 32'(!s.sync_locked || (s.is_active && s.sync_holdover)),
          32'(leds.holdover));
      cmp("act", 32'(s.is_active ? COL_GREEN : COL_OFF), 32'(acol));
    end
    s.config_unknown = 1'b1;
    put(s);
    cmp("act red", 32'(COL_RED), 32'(acol));
    s = nom();
    s.l2_up = 1'b0;
    put(s);
    cmp("link", 32'h0, 32'(leds.backhaul));
    m = '0;
    m.backhaul = 1'b1;
    s.l2_download = 1'b1;
    blink(s, m);
  endtask
  task automatic t_irq;
    slt_status_t s;
    s = nom();
    put(s);
    wr(SLT_OFS_IRQ_STS, 32'hF);
    wr(SLT_OFS_IRQ_MSK, 32'h0);
    s.board = BS_ALARM;
    put(s);
    rd(SLT_OFS_IRQ_STS, 32'h2);
    cmp("irq masked", 32'h0, 32'(irq));
    wr(SLT_OFS_IRQ_MSK, 32'h2);
    cmp("irq", 32'h1, 32'(irq));
    wr(SLT_OFS_IRQ_STS, 32'h2);
    cmp("irq clear", 32'h0, 32'(irq));
    rd(SLT_OFS_IRQ_MSK, 32'h2);
    s = nom();
    s.sync_mode = SM_GPS;
    s.sync_locked = 1'b0;
    s.l2_up = 1'b0;
    put(s);
    s.sync_locked = 1'b1;
    put(s);
    rd(SLT_OFS_IRQ_STS, 32'hD);
    wr(SLT_OFS_CTRL, 32'h0);
    put(nom());
    cmp("dark", 32'h0, 32'(leds));
    wr(SLT_OFS_CTRL, 32'h1);
    rd(SLT_OFS_CTRL, 32'h1);
  endtask
  task automatic t_ce;
    slt_status_t s;
    s = nom();
    put(s);
    @(posedge clk);
    ce <= 1'b0;
    s.board = BS_OFF;
    st <= s;
    repeat (3) @(posedge clk);
    #1 cmp("frozen", 32'h1, 32'({leds.corp_red, leds.corp_green}));
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1 cmp("thawed", 32'h0, 32'({leds.corp_red, leds.corp_green}));
  endtask

  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    err_total = 0;
    n_compared = 0;
    reset = 1'b1;
    ce = 1'b1;
    st = '0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    put('0);
    cmp("reset leds", 32'h0, 32'(leds));
    rd(SLT_OFS_CTRL, 32'h1);
    rd(SLT_OFS_IRQ_MSK, 32'h0);
    rd(8'h14, 32'h0);
    t_corp();
    t_trunk();
    t_sync();
    t_triple();
    t_misc();
    t_irq();
    t_ce();
    report_and_stop();
  end
endmodule
